// ==== hdl/input_capture_unit.v ====
// input capture unit: free-running time base latched into a small fifo
// on selected edges of the capture input pin.
// assumes all inputs are synchronous to sys_clk and a register master
// that never strobes read and write in the same cycle.
//
// Function
// - capture-select high puts the module in capture mode, the only mode
// - mode field picks edge behaviour; wide select picks 16 or 32 bits
// - dedicated up-counter time base written into fifo on each capture
// - time base readable by software one cycle behind the count
// - reset or disable clears flags, fifo, time base, prescaler, events
// - three-bit field selects one of eight time base clock sources
// - wide mode: time base and buffer are 32 bits, split high/low
// - input sampled on timer tick; source holds pulses over a tick
// - simple modes capture value lags edge by up to 1.5 cycles
// - prescaled modes capture value one to two ticks after edge
// - edge detect captures both edges; events continue with the fifo full
// - not-empty sets on capture, clears when all read; reads pop
// - capture into full fifo sets overflow, dropped; stores stop
// - no overflow outside capture mode or in edge detect mode
// - disabled: flags clear, fifo empty, buffer reads return zero
// - software clearing overflow resets pointers, drops data, clears
// - once overflow cleared both flags clear and capture resumes
// - fifo contents undefined after re-enable
// - read after empty returns first buffer location
// - read pointer advances only on most significant word read
// - postscaler sets events per interrupt; draining clears counter
// - on overflow events stop unless postscaler is every capture
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "input_capture_unit_map.vh"

module input_capture_unit
(
	input wire sys_clk,
	input wire rst,
	input wire [2:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	input wire capture_input_pin,
	input wire external_timer_clock_pin,
	output reg capture_interrupt_flag,
	output wire fifo_not_empty_flag,
	output wire fifo_overflow_flag
);

// ----------------------------------------------------------------------
// control registers
// ----------------------------------------------------------------------
reg [15:0] control_one_low_reg;
reg [15:0] control_one_high_reg;

wire [3:0] capture_mode_field;
wire capture_select;
wire wide_timebase_select;
wire [2:0] timebase_clock_select;
wire module_enable;
wire [3:0] interrupt_postscaler;
wire active;

assign capture_mode_field = control_one_low_reg[`MODE_MSB:`MODE_LSB];
assign capture_select = control_one_low_reg[`CAPTURE_SELECT_BIT];
assign wide_timebase_select = control_one_low_reg[`WIDE_SELECT_BIT];
assign timebase_clock_select = control_one_low_reg[`CLKSEL_MSB:`CLKSEL_LSB];
assign module_enable = control_one_low_reg[`ENABLE_BIT];
assign interrupt_postscaler =
	control_one_high_reg[`POSTSCALER_MSB:`POSTSCALER_LSB];
// capture logic runs only with both bits set
assign active = module_enable & capture_select;

always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		control_one_low_reg <= `CONTROL_ONE_LOW_RESET;
		control_one_high_reg <= `CONTROL_ONE_HIGH_RESET;
	end
	else if (reg_wr)
	begin
		if (reg_addr == `ADDR_CONTROL_ONE_LOW)
			control_one_low_reg <= reg_wdata;
		if (reg_addr == `ADDR_CONTROL_ONE_HIGH)
			control_one_high_reg <= reg_wdata;
	end
end

// ----------------------------------------------------------------------
// time base clock source
// ----------------------------------------------------------------------
// sources 2..7 divide sys_clk by 2..64; the divider runs only while active
reg [5:0] div_reg;
reg ext_clk_prev_reg;
reg [5:0] div_mask;
reg tick;

always @*
begin
	div_mask = 6'h00;
	case (timebase_clock_select)
		3'h2: div_mask = 6'h01;
		3'h3: div_mask = 6'h03;
		3'h4: div_mask = 6'h07;
		3'h5: div_mask = 6'h0f;
		3'h6: div_mask = 6'h1f;
		3'h7: div_mask = 6'h3f;
		default: div_mask = 6'h00;
	endcase
	case (timebase_clock_select)
		`CLKSRC_SYSTEM: tick = active;
		`CLKSRC_EXTERNAL_PIN:
			tick = active & external_timer_clock_pin & ~ext_clk_prev_reg;
		default: tick = active & ((div_reg & div_mask) == div_mask);
	endcase
end

always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		div_reg <= 6'h00;
		ext_clk_prev_reg <= 1'b0;
	end
	else
	begin
		ext_clk_prev_reg <= external_timer_clock_pin;
		if (!active)
			div_reg <= 6'h00;
		else
			div_reg <= div_reg + 6'h01;
	end
end

// ----------------------------------------------------------------------
// time base
// ----------------------------------------------------------------------
reg [31:0] timebase_reg;
reg [31:0] timebase_shadow_reg;

always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		timebase_reg <= 32'h00000000;
		timebase_shadow_reg <= 32'h00000000;
	end
	else
	begin
		// software sees the count through a one-cycle shadow
		timebase_shadow_reg <= timebase_reg;
		if (!active)
			timebase_reg <= 32'h00000000;
		else if (tick)
		begin
			if (wide_timebase_select)
				timebase_reg <= timebase_reg + 32'h00000001;
			else
				timebase_reg <= {16'h0000, timebase_reg[15:0] + 16'h0001};
		end
	end
end

// ----------------------------------------------------------------------
// edge detection and prescaler
// ----------------------------------------------------------------------
reg pin_prev_reg;
reg [3:0] prescale_reg;
reg simple_req_reg;
reg prescale_pending_reg;
wire rise;
wire fall;
wire prescaled_mode;
wire [3:0] prescale_top;
reg simple_event;

// pin is looked at only on a tick, standing in for the falling edge
assign rise = tick & capture_input_pin & ~pin_prev_reg;
assign fall = tick & ~capture_input_pin & pin_prev_reg;
assign prescaled_mode = (capture_mode_field == `MODE_FOURTH_RISE) |
	(capture_mode_field == `MODE_SIXTEENTH_RISE);
assign prescale_top = (capture_mode_field == `MODE_FOURTH_RISE) ?
	`PRESCALE_FOURTH : `PRESCALE_SIXTEENTH;

always @*
begin
	case (capture_mode_field)
		`MODE_EDGE_DETECT: simple_event = rise | fall;
		`MODE_EVERY_RISE: simple_event = rise;
		`MODE_EVERY_FALL: simple_event = fall;
		`MODE_EVERY_EDGE: simple_event = rise | fall;
		default: simple_event = 1'b0;
	endcase
end

always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		pin_prev_reg <= 1'b0;
		prescale_reg <= 4'h0;
		simple_req_reg <= 1'b0;
		prescale_pending_reg <= 1'b0;
	end
	else if (!active)
	begin
		pin_prev_reg <= 1'b0;
		prescale_reg <= 4'h0;
		simple_req_reg <= 1'b0;
		prescale_pending_reg <= 1'b0;
	end
	else
	begin
		if (tick)
			pin_prev_reg <= capture_input_pin;
		// one cycle of lag keeps the capture within 1.5 cycles of the edge
		simple_req_reg <= simple_event;
		if (prescaled_mode && rise)
		begin
			if (prescale_reg == prescale_top)
			begin
				prescale_reg <= 4'h0;
				prescale_pending_reg <= 1'b1;
			end
			else
				prescale_reg <= prescale_reg + 4'h1;
		end
		else if (prescale_pending_reg && tick)
			prescale_pending_reg <= 1'b0;
	end
end

// ----------------------------------------------------------------------
// capture fifo
// ----------------------------------------------------------------------
reg [15:0] fifo_low_mem [0:3];
reg [15:0] fifo_high_mem [0:3];
reg [1:0] wr_ptr_reg;
reg [1:0] rd_ptr_reg;
reg [2:0] count_reg;
reg overflow_reg;
reg not_empty_reg;
reg [3:0] event_count_reg;

wire attempt;
wire [2:0] depth;
wire full;
wire edge_mode;
wire push;
wire pop_word;
wire pop;
wire sw_clear;
wire ovf_set;
wire drained;
wire event_ok;
wire [3:0] ops_limit;
wire [1:0] wr_ptr_inc;
wire [1:0] rd_ptr_inc;
wire [2:0] count_sum;

// prescaled value is taken on the tick after the qualifying edge
assign attempt = simple_req_reg | (prescale_pending_reg & tick);
assign depth = wide_timebase_select ? `DEPTH_WIDE : `DEPTH_NARROW;
assign full = (count_reg == depth);
assign edge_mode = (capture_mode_field == `MODE_EDGE_DETECT);
assign push = active & attempt & ~full & ~overflow_reg;
assign ovf_set = active & attempt & full & ~edge_mode;
// only the most significant word moves the read pointer
assign pop_word = wide_timebase_select ?
	(reg_addr == `ADDR_BUFFER_HIGH) : (reg_addr == `ADDR_BUFFER_LOW);
assign pop = active & reg_rd & pop_word & (count_reg != 3'h0);
assign sw_clear = active & reg_wr &
	(reg_addr == `ADDR_CAPTURE_STATUS_LOW) &
	~reg_wdata[`OVERFLOW_BIT] & overflow_reg;
assign count_sum = count_reg + {2'b00, push} - {2'b00, pop};
assign drained = pop & (count_sum == 3'h0);
assign wr_ptr_inc = ({1'b0, wr_ptr_reg} == depth - 3'h1) ?
	2'h0 : wr_ptr_reg + 2'h1;
assign rd_ptr_inc = ({1'b0, rd_ptr_reg} == depth - 3'h1) ?
	2'h0 : rd_ptr_reg + 2'h1;
// edge detect keeps interrupting with the fifo full; else only every capture
assign event_ok = push | (active & attempt & (edge_mode |
	(interrupt_postscaler == 4'h0)));
assign ops_limit = (interrupt_postscaler > `POSTSCALE_MAX) ?
	`POSTSCALE_MAX : interrupt_postscaler;

// memory keeps its contents over disable; they count as undefined
always @(posedge sys_clk)
begin
	if (push)
	begin
		fifo_low_mem[wr_ptr_reg] <= timebase_reg[15:0];
		fifo_high_mem[wr_ptr_reg] <= timebase_reg[31:16];
	end
end

always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		wr_ptr_reg <= 2'h0;
		rd_ptr_reg <= 2'h0;
		count_reg <= 3'h0;
		overflow_reg <= 1'b0;
		not_empty_reg <= 1'b0;
		event_count_reg <= 4'h0;
		capture_interrupt_flag <= 1'b0;
	end
	else if (!active)
	begin
		wr_ptr_reg <= 2'h0;
		rd_ptr_reg <= 2'h0;
		count_reg <= 3'h0;
		overflow_reg <= 1'b0;
		not_empty_reg <= 1'b0;
		event_count_reg <= 4'h0;
		capture_interrupt_flag <= 1'b0;
	end
	else
	begin
		// a fresh overflow in the clear cycle wins over the clear
		if (sw_clear && !ovf_set)
		begin
			wr_ptr_reg <= 2'h0;
			rd_ptr_reg <= 2'h0;
			count_reg <= 3'h0;
			overflow_reg <= 1'b0;
			not_empty_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_sum;
			not_empty_reg <= (count_sum != 3'h0);
			if (count_sum == 3'h0)
			begin
				// both pointers rest on the first location when empty
				wr_ptr_reg <= 2'h0;
				rd_ptr_reg <= 2'h0;
			end
			else
			begin
				if (push)
					wr_ptr_reg <= wr_ptr_inc;
				if (pop)
					rd_ptr_reg <= rd_ptr_inc;
			end
			if (ovf_set)
				overflow_reg <= 1'b1;
			else if (drained)
				overflow_reg <= 1'b0;
		end
		capture_interrupt_flag <= 1'b0;
		if (event_ok)
		begin
			if (event_count_reg >= ops_limit)
			begin
				event_count_reg <= 4'h0;
				capture_interrupt_flag <= 1'b1;
			end
			else
				event_count_reg <= event_count_reg + 4'h1;
		end
		else if (drained || sw_clear)
			event_count_reg <= 4'h0;
	end
end

assign fifo_not_empty_flag = not_empty_reg;
assign fifo_overflow_flag = overflow_reg;

// ----------------------------------------------------------------------
// register read port
// ----------------------------------------------------------------------
always @(posedge sys_clk or posedge rst)
begin
	if (rst)
		reg_rdata <= 16'h0000;
	else if (reg_rd)
	begin
		case (reg_addr)
			`ADDR_CONTROL_ONE_LOW: reg_rdata <= control_one_low_reg;
			`ADDR_CONTROL_ONE_HIGH: reg_rdata <= control_one_high_reg;
			`ADDR_CAPTURE_STATUS_LOW:
				reg_rdata <= {14'h0000, overflow_reg, not_empty_reg};
			`ADDR_TIMEBASE_LOW: reg_rdata <= timebase_shadow_reg[15:0];
			`ADDR_TIMEBASE_HIGH: reg_rdata <= timebase_shadow_reg[31:16];
			`ADDR_BUFFER_LOW:
				reg_rdata <= active ? fifo_low_mem[rd_ptr_reg] :
					16'h0000;
			`ADDR_BUFFER_HIGH:
				reg_rdata <= (active && wide_timebase_select) ?
					fifo_high_mem[rd_ptr_reg] : 16'h0000;
			default: reg_rdata <= 16'h0000;
		endcase
	end
end

endmodule // input_capture_unit

// ==== hdl/input_capture_unit_map.vh ====
// register map, field positions, reset values and mode codes of the
// input capture unit; included by the design file only
`ifndef INPUT_CAPTURE_UNIT_MAP_VH
`define INPUT_CAPTURE_UNIT_MAP_VH

// ----------------------------------------------------------------------
// word addresses on the register port
// ----------------------------------------------------------------------
`define ADDR_CONTROL_ONE_LOW 3'h0
`define ADDR_CONTROL_ONE_HIGH 3'h1
`define ADDR_CAPTURE_STATUS_LOW 3'h2
`define ADDR_TIMEBASE_LOW 3'h3
`define ADDR_TIMEBASE_HIGH 3'h4
`define ADDR_BUFFER_LOW 3'h5
`define ADDR_BUFFER_HIGH 3'h6

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MODE_LSB 0
`define MODE_MSB 3
`define CAPTURE_SELECT_BIT 4
`define WIDE_SELECT_BIT 5
`define CLKSEL_LSB 8
`define CLKSEL_MSB 10
`define ENABLE_BIT 15
`define POSTSCALER_LSB 8
`define POSTSCALER_MSB 11
`define NOT_EMPTY_BIT 0
`define OVERFLOW_BIT 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CONTROL_ONE_LOW_RESET 16'h0000
`define CONTROL_ONE_HIGH_RESET 16'h0000

// ----------------------------------------------------------------------
// capture modes and clock sources
// ----------------------------------------------------------------------
`define MODE_EDGE_DETECT 4'h0
`define MODE_EVERY_RISE 4'h1
`define MODE_EVERY_FALL 4'h2
`define MODE_EVERY_EDGE 4'h3
`define MODE_FOURTH_RISE 4'h4
`define MODE_SIXTEENTH_RISE 4'h5
`define CLKSRC_SYSTEM 3'h0
`define CLKSRC_EXTERNAL_PIN 3'h1

// ----------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------
`define DEPTH_NARROW 3'h4
`define DEPTH_WIDE 3'h2
`define PRESCALE_FOURTH 4'h3
`define PRESCALE_SIXTEENTH 4'hf
`define POSTSCALE_MAX 4'h3

`endif

// ==== sim/input_capture_unit_chk.sv ====
// port-level assertions for the input capture unit
// assumes it is bound to the unit and sees only the unit's ports
`timescale 1ns/1ps
module input_capture_unit_chk
(
	input wire sys_clk,
	input wire rst,
	input wire [2:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire capture_input_pin,
	input wire external_timer_clock_pin,
	input wire capture_interrupt_flag,
	input wire fifo_not_empty_flag,
	input wire fifo_overflow_flag
);
	// --------------------------------
	// shadow of the control word
	// --------------------------------
	reg [15:0] ctl_reg;
	reg [2:0] pin_hist_reg;
	wire cap_on = ctl_reg[15] & ctl_reg[4];
	// a pin quiet for three samples means no capture is in flight
	wire quiet = pin_hist_reg == {3{capture_input_pin}};
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctl_reg <= 16'h0000;
			pin_hist_reg <= 3'h0;
		end
		else
		begin
			if (reg_wr && reg_addr == 3'h0)
				ctl_reg <= reg_wdata;
			pin_hist_reg <= {pin_hist_reg[1:0], capture_input_pin};
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_off_clear;
		!cap_on |=> !fifo_not_empty_flag && !fifo_overflow_flag;
	endproperty
	a_off_clear: assert property (p_off_clear)
		else $error("flag set while off");
	property p_edge_no_ovf;
		$rose(fifo_overflow_flag) |-> $past(cap_on) &&
			$past(ctl_reg[3:0]) != 4'h0;
	endproperty
	a_edge_no_ovf: assert property (p_edge_no_ovf)
		else $error("overflow in edge detect or off");
	property p_status_read;
		reg_rd && reg_addr == 3'h2 |=> reg_rdata == {14'h0000,
			$past(fifo_overflow_flag), $past(fifo_not_empty_flag)};
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read wrong");
	property p_unmapped;
		reg_rd && reg_addr == 3'h7 |=> reg_rdata == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without read");
	property p_ovf_full;
		fifo_overflow_flag |-> fifo_not_empty_flag;
	endproperty
	a_ovf_full: assert property (p_ovf_full)
		else $error("overflow with empty fifo");
	property p_sw_clear;
		reg_wr && reg_addr == 3'h2 && !reg_wdata[1] && fifo_overflow_flag
			&& quiet && ctl_reg[10:8] == 3'h0
			|=> !fifo_overflow_flag && !fifo_not_empty_flag;
	endproperty
	a_sw_clear: assert property (p_sw_clear)
		else $error("overflow clear left flags");
	property p_off_read;
		reg_rd && reg_addr == 3'h5 && !cap_on |=> reg_rdata == 16'h0000;
	endproperty
	a_off_read: assert property (p_off_read)
		else $error("buffer read nonzero while off");
endmodule // input_capture_unit_chk

bind input_capture_unit input_capture_unit_chk chk
(
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .capture_input_pin(capture_input_pin),
	.external_timer_clock_pin(external_timer_clock_pin),
	.capture_interrupt_flag(capture_interrupt_flag),
	.fifo_not_empty_flag(fifo_not_empty_flag),
	.fifo_overflow_flag(fifo_overflow_flag)
);

// ==== sim/signal_source.sv ====
// signal source model: drives the capture input and the external clock
// assumes the bench calls its tasks; outputs change after sys_clk rises
`timescale 1ns/1ps
module signal_source
(
	input wire sys_clk,
	output reg capture_input_pin,
	output reg external_timer_clock_pin
);
	initial
	begin
		capture_input_pin = 1'b0;
		external_timer_clock_pin = 1'b0;
	end
	// --------------------------------
	// stimulus tasks
	// --------------------------------
	// each level lasts w cycles, so more than one timer tick
	task pulses(input integer n, input integer w);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1)
			begin
				@(posedge sys_clk);
				capture_input_pin <= 1'b1;
				repeat (w) @(posedge sys_clk);
				capture_input_pin <= 1'b0;
				repeat (w - 1) @(posedge sys_clk);
			end
		end
	endtask
	task ticks(input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1)
			begin
				@(posedge sys_clk);
				external_timer_clock_pin <= 1'b1;
				repeat (2) @(posedge sys_clk);
				external_timer_clock_pin <= 1'b0;
				@(posedge sys_clk);
			end
		end
	endtask
endmodule // signal_source

// ==== sim/testbench.sv ====
// self-checking bench for the input capture unit
// assumes the unit, its checker and the signal source are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done = checks_done + 1; \
	if ((g) !== (e)) begin mismatches = mismatches + 1; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
module testbench;
	reg sys_clk, rst, reg_wr, reg_rd;
	reg [2:0] reg_addr;
	reg [15:0] reg_wdata, v, a0, a1;
	reg [31:0] w0, w1;
	wire [15:0] reg_rdata;
	wire pin, ext, irq, ne, ovf;
	integer mismatches, checks_done, irq_n, i;
	input_capture_unit DUT (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_input_pin(pin),
		.external_timer_clock_pin(ext), .capture_interrupt_flag(irq),
		.fifo_not_empty_flag(ne), .fifo_overflow_flag(ovf));
	signal_source src (.sys_clk(sys_clk), .capture_input_pin(pin),
		.external_timer_clock_pin(ext));
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (irq === 1'b1)
			irq_n = irq_n + 1;
	// --------------------------------
	// bus tasks and verdict
	// --------------------------------
	task wr(input [2:0] a, input [15:0] d);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	end
	endtask
	task rd(input [2:0] a);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
	end
	endtask
	task summarize;
	begin
		if (mismatches == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	function integer irq_exp(input integer m);
		irq_exp = (m == 0 || m == 3) ? 32 : (m == 4) ? 4 : (m == 5) ? 1 : 16;
	endfunction
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		mismatches = mismatches + 1;
		summarize;
	end
	initial
	begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		mismatches = 0;
		checks_done = 0;
		irq_n = 0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i = i + 1)
		begin
			rd(i[2:0]);
			`CHK("reset read", 16'h0000, v)
		end
		// every mode, 16 pulses, interrupt on every event
		for (i = 0; i < 6; i = i + 1)
		begin
			wr(3'h0, 16'h0000);
			wr(3'h1, 16'h0000);
			wr(3'h0, 16'h8010 | i[15:0]);
			irq_n = 0;
			src.pulses(16, 2);
			repeat (8) @(posedge sys_clk);
			`CHK("irq count", irq_exp(i), irq_n)
			rd(3'h2);
			`CHK("mode status", {14'h0, i >= 1 && i <= 3, 1'b1}, v)
		end
		wr(3'h0, 16'h0000);
		wr(3'h1, 16'h0300);
		wr(3'h0, 16'h8011);
		irq_n = 0;
		src.pulses(4, 3);
		repeat (8) @(posedge sys_clk);
		`CHK("fourth irq", 1, irq_n)
		rd(3'h5);
		a0 = v;
		a1 = v;
		`CHK("first capture", 16'h0002, a0)
		for (i = 0; i < 3; i = i + 1)
		begin
			rd(3'h5);
			`CHK("capture step", 16'h0006, v - a1)
			a1 = v;
		end
		rd(3'h2);
		`CHK("drained", 16'h0000, v)
		rd(3'h5);
		`CHK("read past empty", a0, v)
		rd(3'h3);
		a1 = v;
		rd(3'h3);
		`CHK("timebase step", a1 + 16'h0002, v)
		// wide mode: three rises overflow a two-entry fifo
		wr(3'h0, 16'h0000);
		wr(3'h0, 16'h8031);
		src.pulses(3, 3);
		repeat (8) @(posedge sys_clk);
		rd(3'h5);
		w0[15:0] = v;
		rd(3'h5);
		`CHK("low read repeat", w0[15:0], v)
		rd(3'h2);
		`CHK("wide overflow", 16'h0003, v)
		`CHK("flag pins", 2'b11, {ovf, ne})
		rd(3'h6);
		w0[31:16] = v;
		rd(3'h5);
		w1[15:0] = v;
		rd(3'h6);
		w1[31:16] = v;
		`CHK("wide step", 32'h00000006, w1 - w0)
		rd(3'h2);
		`CHK("wide drained", 16'h0000, v)
		wr(3'h0, 16'h0000);
		wr(3'h0, 16'h8011);
		src.pulses(5, 3);
		repeat (8) @(posedge sys_clk);
		wr(3'h2, 16'h0000);
		rd(3'h2);
		`CHK("sw clear", 16'h0000, v)
		src.pulses(1, 3);
		repeat (8) @(posedge sys_clk);
		rd(3'h2);
		`CHK("resumed", 16'h0001, v)
		// external pin as time base clock
		wr(3'h0, 16'h0000);
		wr(3'h0, 16'h8111);
		rd(3'h3);
		`CHK("timebase cleared", 16'h0000, v)
		src.ticks(5);
		repeat (4) @(posedge sys_clk);
		rd(3'h3);
		`CHK("external ticks", 16'h0005, v)
		// divide-by-two source: two cycles between samples hold one tick
		wr(3'h0, 16'h0000);
		wr(3'h0, 16'h8211);
		rd(3'h3);
		a1 = v;
		rd(3'h3);
		`CHK("divided step", a1 + 16'h0001, v)
		summarize;
	end
endmodule // testbench
